// ---- logic/nfc_ctrl.sv ----
/*
 Host-side controller for one parallel NOR flash: turns software
 operations into unlock/command write sequences and array reads.
 Assumes a synchronous 100 MHz core and an asynchronous flash whose
 ready/busy and status bits come in on pins (synchronised here).
*/
// Notes on behaviour
// - Host writes reset after ident or timeout
// - Ident is two unlocks plus bank command
// - No ident while another bank is busy
// - Protection read needs bank and sector address
// - Three-cycle secure entry, four-cycle exit
// - Word program is four write cycles
// - Hardware reset aborts; reissue full program
// - Bypass entry with 20h, program with A0h
// - Bad sequence needs a reset command
`timescale 1ns/1ps
`default_nettype none

module nfc_ctrl
   import nfc_pkg::*;
#(
   parameter int DW = 16
)(
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   output logic      [ADDR_W-1:0] fl_addr,
   output logic      [DW-1:0]     fl_dq_o,
   output logic                   fl_dq_oe,
   input  wire logic [DW-1:0]     fl_dq_i,
   output logic                   fl_we_n,
   output logic                   fl_oe_n,
   output logic                   fl_ce_n,
   input  wire logic              ready_busy_output,
   output logic                   protect_accelerate_pin
);

   ////////////////////////////////////////////////////////////////////
   // Sequencer states, Gray-coded from S_IDLE through S_SETUP and S_WLOW to S_WHIGH
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_SETUP = 3'b001,
      S_WLOW  = 3'b011,
      S_WHIGH = 3'b010,
      S_RLOW  = 3'b110,
      S_WAIT  = 3'b111
   } nfc_state_t;

   nfc_state_t        state_r;
   nfc_cycle_t        seq_r [4];
   logic [2:0]        seq_len_r;
   logic [2:0]        seq_idx_r;
   logic [3:0]        cnt_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DW-1:0]     wdata_r;
   logic [DW-1:0]     rdata_r;
   logic              bypass_r;
   logic              secure_r;
   logic              ident_r;
   logic              busy_wait_r;
   logic              refused_r;
   logic              accel_r;
   logic [1:0]        rb_sync_r;
   logic [DW-1:0]     dq_meta_r;
   logic [DW-1:0]     dq_sync_r;

   // Far pins pass two flops before use
   always_ff @(posedge core_clk)
   begin
      rb_sync_r <= {rb_sync_r[0], ready_busy_output};
      dq_meta_r <= fl_dq_i;
      dq_sync_r <= dq_meta_r;   // Bus stands for the whole read, so two flops suffice
   end

   wire logic rb_ready  = rb_sync_r[1];
   wire logic tlim_flag = dq_sync_r[5];   // timing_limit_flag while busy

   ////////////////////////////////////////////////////////////////////
   // Register decode and operation legality
   wire logic    wr_ctrl = reg_wr && reg_addr == REG_CTRL;
   wire nfc_op_t op      = nfc_op_t'(reg_wdata[3:0]);
   wire logic    idle    = state_r == S_IDLE;

   // bypass only takes program and bypass reset
   function automatic logic op_ok(input nfc_op_t o, input logic byp,
                                  input logic sec);
      if (byp)
         op_ok = (o == NFC_OP_BYP_PROG) || (o == NFC_OP_BYP_OUT);
      else if (sec)
         // no bypass while secure region mapped
         op_ok = (o != NFC_OP_BYP_IN) && (o != NFC_OP_BYP_PROG);
      else
         op_ok = (o != NFC_OP_BYP_PROG) && (o != NFC_OP_BYP_OUT);
   endfunction

   // nothing launched while busy
   // Codes past the last op are refused; raised pin counts as bypass
   wire logic accept = wr_ctrl && idle && rb_ready && reg_wdata[3:0] <= NFC_OP_BYP_OUT &&
                       op_ok(op, bypass_r || accel_r, secure_r);

   wire nfc_cycle_t u1 = '{addr: {10'h000, UNLOCK_ADDR1}, data: UNLOCK_DATA1};
   wire nfc_cycle_t u2 = '{addr: {10'h000, UNLOCK_ADDR2}, data: UNLOCK_DATA2};
   wire logic [ADDR_W-1:0] ba_unl = {addr_r[ADDR_W-1:12], UNLOCK_ADDR1};

   ////////////////////////////////////////////////////////////////////
   // Build command sequence for an accepted operation
   nfc_cycle_t nseq [4];
   logic [2:0] nlen;
   always_comb
   begin
      nseq[0] = u1;
      nseq[1] = u2;
      nseq[2] = '0;
      nseq[3] = '0;
      nlen    = 3'd0;
      case (op)
         NFC_OP_RESET:
         begin
            nseq[0] = '{addr: addr_r, data: CMD_RESET};
            nlen    = 3'd1;
         end
         // two unlocks then bank address with command
         NFC_OP_IDENT:
         begin
            nseq[2] = '{addr: ba_unl, data: CMD_IDENT};
            nlen    = 3'd3;
         end
         NFC_OP_SEC_IN:
         begin
            nseq[2] = '{addr: {10'h000, UNLOCK_ADDR1}, data: CMD_SEC_ENTER};
            nlen    = 3'd3;
         end
         NFC_OP_SEC_OUT:
         begin
            nseq[2] = '{addr: {10'h000, UNLOCK_ADDR1}, data: CMD_SEC_EXIT};
            nseq[3] = '{addr: '0, data: CMD_SEC_EXIT2};
            nlen    = 3'd4;
         end
         // two unlocks, set-up, address with data
         NFC_OP_PROGRAM:
         begin
            nseq[2] = '{addr: {10'h000, UNLOCK_ADDR1}, data: CMD_PROG_SETUP};
            nseq[3] = '{addr: addr_r, data: wdata_r};
            nlen    = 3'd4;
         end
         // bypass entry and two-write bypass program
         NFC_OP_BYP_IN:
         begin
            nseq[2] = '{addr: {10'h000, UNLOCK_ADDR1}, data: CMD_BYPASS};
            nlen    = 3'd3;
         end
         NFC_OP_BYP_PROG:
         begin
            nseq[0] = '{addr: addr_r, data: CMD_PROG_SETUP};
            nseq[1] = '{addr: addr_r, data: wdata_r};
            nlen    = 3'd2;
         end
         NFC_OP_BYP_OUT:
         begin
            nseq[0] = '{addr: addr_r, data: CMD_BYP_RESET1};
            nseq[1] = '{addr: addr_r, data: CMD_BYP_RESET2};
            nlen    = 3'd2;
         end
         default:
            nlen = 3'd0;
      endcase
   end

   wire logic is_prog  = op == NFC_OP_PROGRAM || op == NFC_OP_BYP_PROG;
   wire logic cnt_done = cnt_r == 4'd0;
   wire logic last_wr  = seq_idx_r == seq_len_r - 3'd1;

   ////////////////////////////////////////////////////////////////////
   // Configuration registers from software
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         addr_r  <= '0;
         wdata_r <= '0;
         accel_r <= 1'b0;
      end
      else if (reg_wr && reg_addr == REG_ADDR)
         addr_r <= reg_wdata[ADDR_W-1:0];
      else if (reg_wr && reg_addr == REG_WDATA)
         wdata_r <= reg_wdata[DW-1:0];
      // accelerate only on accepted ops, never with secure
      else if (accept)
         accel_r <= reg_wdata[8] && !secure_r && op != NFC_OP_SEC_IN;
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer: write cycles, array reads, busy wait
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_r     <= S_IDLE;
         seq_len_r   <= '0;
         seq_idx_r   <= '0;
         cnt_r       <= '0;
         busy_wait_r <= 1'b0;
         for (int i = 0; i < 4; i++)
            seq_r[i] <= '0;
      end
      else
      begin
         if (cnt_r != 4'd0)
            cnt_r <= cnt_r - 4'd1;
         case (state_r)
            S_IDLE:
               if (accept && op == NFC_OP_READ)
               begin
                  state_r <= S_RLOW;
                  cnt_r   <= 4'(RD_CYC);
               end
               else if (accept)
               begin
                  seq_r       <= nseq;
                  seq_len_r   <= nlen;
                  seq_idx_r   <= '0;
                  busy_wait_r <= is_prog;
                  state_r     <= S_SETUP;
               end
            S_SETUP:
            begin
               state_r <= S_WLOW;
               cnt_r   <= 4'(WE_LOW_CYC);
            end
            S_WLOW:
               if (cnt_done)
               begin
                  state_r <= S_WHIGH;
                  cnt_r   <= 4'(WE_HIGH_CYC);
               end
            S_WHIGH:
               if (cnt_done && !last_wr)
               begin
                  seq_idx_r <= seq_idx_r + 3'd1;
                  state_r   <= S_SETUP;
               end
               else if (cnt_done)
               begin
                  state_r <= busy_wait_r ? S_WAIT : S_IDLE;
                  cnt_r   <= 4'(RD_CYC);
               end
            S_WAIT:
               if (cnt_done && rb_ready)
                  state_r <= S_IDLE;
            S_RLOW:
               if (cnt_done)
                  state_r <= S_IDLE;
            default:
               state_r <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Mode tracking as seen by the host
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         bypass_r  <= 1'b0;
         secure_r  <= 1'b0;
         ident_r   <= 1'b0;
         refused_r <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         refused_r <= !accept;
         if (accept)
            case (op)
               NFC_OP_RESET:    ident_r  <= 1'b0;
               NFC_OP_IDENT:    ident_r  <= 1'b1;
               NFC_OP_SEC_IN:   secure_r <= 1'b1;
               NFC_OP_SEC_OUT:  secure_r <= 1'b0;
               NFC_OP_BYP_IN:   bypass_r <= 1'b1;
               NFC_OP_BYP_OUT:  bypass_r <= 1'b0;
               default:         bypass_r <= bypass_r;
            endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin drive, all from flops
   wire nfc_cycle_t cur = seq_r[seq_idx_r[1:0]];
   wire logic writing   = state_r == S_SETUP || state_r == S_WLOW || state_r == S_WHIGH;
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         fl_addr                <= '0;
         fl_dq_o                <= '0;
         fl_dq_oe               <= 1'b0;
         fl_we_n                <= 1'b1;
         fl_oe_n                <= 1'b1;
         fl_ce_n                <= 1'b1;
         protect_accelerate_pin <= 1'b0;
         rdata_r                <= '0;
      end
      else
      begin
         fl_addr  <= writing ? cur.addr : addr_r;
         fl_dq_o  <= cur.data;
         fl_dq_oe <= writing;
         fl_we_n  <= state_r != S_WLOW;
         fl_oe_n  <= !(state_r == S_RLOW || state_r == S_WAIT);
         fl_ce_n  <= state_r == S_IDLE;
         protect_accelerate_pin <= accel_r;
         // status read back comes from flash unchanged
         if (state_r == S_RLOW && cnt_done)
            rdata_r <= dq_sync_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read port, one cycle after strobe
   wire logic [31:0] status_w = {24'h000000, refused_r, tlim_flag, accel_r,
                                 ident_r, secure_r, bypass_r, rb_ready, !idle};
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         reg_rdata <= '0;
      else if (reg_rd)
         case (reg_addr)
            REG_ADDR:   reg_rdata <= 32'(addr_r);
            REG_WDATA:  reg_rdata <= 32'(wdata_r);
            REG_STATUS: reg_rdata <= status_w;
            REG_RDATA:  reg_rdata <= 32'(rdata_r);
            default:    reg_rdata <= '0;
         endcase
      else
         reg_rdata <= '0;
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   // no bypass program outside bypass
   bypass_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_ctrl && op == NFC_OP_BYP_PROG && !bypass_r && !accel_r |-> !accept)
      else $error("bypass program accepted outside bypass");
   secure_accel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      secure_r |-> !accel_r)
      else $error("accelerate raised in secure mode");
   busy_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_ctrl && (!rb_ready || !idle) |-> ##1 refused_r)
      else $error("command accepted while busy");
   // strobe low only with data driven
   strobe_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !fl_we_n |-> fl_dq_oe && !fl_ce_n)
      else $error("write strobe without data");
   // program launches a write within bound
   program_go_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && op == NFC_OP_PROGRAM |-> ##[1:4] !fl_we_n)
      else $error("program sequence not started");
   // secure entry sets mode next cycle
   secure_in_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && op == NFC_OP_SEC_IN |=> secure_r)
      else $error("secure mode not set");
   ident_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && op == NFC_OP_RESET |=> !ident_r)
      else $error("ident mode kept after reset");
   wait_ready_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == S_WAIT && !rb_ready |=> state_r == S_WAIT)
      else $error("left busy wait early");

endmodule

`default_nettype wire

// ---- logic/nfc_pkg.sv ----
/*
 Package for the NOR flash bank command controller: command codes,
 unlock addresses, controller register map, pin timing counts.
 Assumes a 100 MHz core clock and a parallel asynchronous NOR flash.
*/
`default_nettype none

package nfc_pkg;

   // Core clock period
   localparam int CLK_NS = 10;

   // Write strobe low/high and read access times in ns, then cycles (round up)
   localparam int T_WE_LOW_NS  = 35;
   localparam int T_WE_HIGH_NS = 30;
   localparam int T_RD_NS      = 70;
   localparam int WE_LOW_CYC   = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_HIGH_CYC  = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_CYC       = (T_RD_NS + CLK_NS - 1) / CLK_NS;

   // Unlock cycle addresses and data, and command codes (fixed localparams)
   localparam logic [11:0] UNLOCK_ADDR1   = 12'h555;
   localparam logic [11:0] UNLOCK_ADDR2   = 12'h2AA;
   localparam logic [15:0] UNLOCK_DATA1   = 16'h00AA;
   localparam logic [15:0] UNLOCK_DATA2   = 16'h0055;
   localparam logic [15:0] CMD_RESET      = 16'h00F0;
   localparam logic [15:0] CMD_IDENT      = 16'h0090;
   localparam logic [15:0] CMD_SEC_ENTER  = 16'h0088;
   localparam logic [15:0] CMD_SEC_EXIT   = 16'h0090;
   localparam logic [15:0] CMD_SEC_EXIT2  = 16'h0000;
   localparam logic [15:0] CMD_PROG_SETUP = 16'h00A0;
   localparam logic [15:0] CMD_BYPASS     = 16'h0020;
   localparam logic [15:0] CMD_BYP_RESET1 = 16'h0090;
   localparam logic [15:0] CMD_BYP_RESET2 = 16'h0000;

   // Controller register offsets
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h1;
   localparam logic [3:0] REG_WDATA  = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_RDATA  = 4'h4;

   // Operation codes written to the control register
   typedef enum logic [3:0] {
      NFC_OP_READ     = 4'h0,
      NFC_OP_RESET    = 4'h1,
      NFC_OP_IDENT    = 4'h2,
      NFC_OP_SEC_IN   = 4'h3,
      NFC_OP_SEC_OUT  = 4'h4,
      NFC_OP_PROGRAM  = 4'h5,
      NFC_OP_BYP_IN   = 4'h6,
      NFC_OP_BYP_PROG = 4'h7,
      NFC_OP_BYP_OUT  = 4'h8
   } nfc_op_t;

   // One flash bus write cycle
   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] data;
   } nfc_cycle_t;

   localparam int ADDR_W = 22;

endpackage

`default_nettype wire

// ---- tb/nfc_flash_model.sv ----
/*
 Behavioural model of one bank of a parallel NOR flash: command
 decoder, identification, secured region, program and bypass modes.
 Assumes the controller drives the pins of nfc_ctrl; no clock of its own.
*/
`timescale 1ns/1ps
`default_nettype none

module nfc_flash_model
   import nfc_pkg::*;
#(
   parameter logic [15:0] ID_CODE = 16'h3C5A,  // Arbitrary identification value
   parameter logic [15:0] SN_BASE = 16'h7100,  // Serial record base, arbitrary
   parameter int          PROG_NS = 2000
)(
   input  wire logic [ADDR_W-1:0] fl_addr,
   input  wire logic [15:0]       fl_dq_o,
   input  wire logic              fl_we_n,
   input  wire logic              fl_oe_n,
   input  wire logic              fl_ce_n,
   input  wire logic              protect_accelerate_pin,
   output logic      [15:0]       fl_dq_i,
   output logic                   ready_busy_output
);
   logic [15:0]       mem [logic [ADDR_W-1:0]];
   logic [ADDR_W-1:0] a_lat;
   logic [15:0]       rd_last = 16'h0000;
   int                mode = 0;  // 0 read, 1 ident, 2 secure, 3 bypass
   int                step = 0;
   logic              pend = 1'b0;
   logic              busy = 1'b0;
   logic              exit_arm = 1'b0;

   // Erased content differs per low address byte so misrouted reads show up
   function automatic logic [15:0] cur(input logic [ADDR_W-1:0] a);
      return mem.exists(a) ? mem[a] : {a[7:0], ~a[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // address on falling strobe
   always @(negedge fl_we_n)
      if (!fl_ce_n)
         a_lat = fl_addr;

   task automatic prog(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      mem[a] = cur(a) & d;
      busy = 1'b1;
      ready_busy_output = 1'b0;
      #(PROG_NS);
      busy = 1'b0;
      ready_busy_output = 1'b1;
   endtask

   initial ready_busy_output = 1'b1;

   // data on rising strobe, decoded against constants
   always @(posedge fl_we_n)
   begin
      if (fl_ce_n)
         ;
      else if (pend)
      begin
         pend = 1'b0;
         step = 0;
         prog(a_lat, fl_dq_o);
      end
      else if (mode == 3)
      begin
         if (fl_dq_o == CMD_PROG_SETUP)
            pend = 1'b1;
         else if (exit_arm && fl_dq_o == CMD_BYP_RESET2)
            mode = 0;
         exit_arm = (fl_dq_o == CMD_BYP_RESET1);
      end
      else if (mode == 2 && exit_arm)
      begin
         mode = (fl_dq_o == CMD_SEC_EXIT2) ? 0 : 2;
         exit_arm = 1'b0;
      end
      else if (fl_dq_o == CMD_RESET)
      begin
         step = 0;
         if (mode == 1)
            mode = 0;
      end
      else if (step == 0 && a_lat[11:0] == UNLOCK_ADDR1 && fl_dq_o == UNLOCK_DATA1)
         step = 1;
      else if (step == 1 && a_lat[11:0] == UNLOCK_ADDR2 && fl_dq_o == UNLOCK_DATA2)
         step = 2;
      else if (step == 2)
      begin
         step = 0;
         if (mode == 2 && fl_dq_o == CMD_SEC_EXIT)
            exit_arm = 1'b1;
         else if (fl_dq_o == CMD_IDENT)
            mode = 1;
         else if (fl_dq_o == CMD_SEC_ENTER)
            mode = 2;
         else if (fl_dq_o == CMD_PROG_SETUP)
            pend = 1'b1;
         else if (fl_dq_o == CMD_BYPASS && mode != 2)
            mode = 3;
      end
      else
         step = 0;
   end

   // elevated pin enters bypass outside secure region
   always @(posedge protect_accelerate_pin)
      if (mode != 2)
         mode = 3;

   // released bus shows inverse of last value
   // no suspend modelled, every sector reads array
   always @(fl_oe_n or fl_ce_n or fl_addr or mode or busy or pend)
   begin
      if (!fl_oe_n && !fl_ce_n)
      begin
         fl_dq_i = busy ? 16'h0000 : (mode == 1) ? ID_CODE :
                   (mode == 2) ? (SN_BASE | {13'h0000, fl_addr[2:0]}) : cur(fl_addr);
         rd_last = fl_dq_i;
      end
      else
         fl_dq_i = ~rd_last;
   end
endmodule

`default_nettype wire

// ---- tb/test_nfc_ctrl.sv ----
/*
 Self-checking bench for nfc_ctrl driving the flash model.
 Assumes the register map and op codes of nfc_pkg and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module test_nfc_ctrl;
   import nfc_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, st, v;
   logic [ADDR_W-1:0] fl_addr;
   logic [15:0] fl_dq_o, fl_dq_i;
   logic fl_dq_oe, fl_we_n, fl_oe_n, fl_ce_n, rb, pap;
   int bad_count = 0, check_count = 0, cyc = 0;

   always #5 core_clk = ~core_clk;

   nfc_ctrl nfc_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
      .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_ce_n(fl_ce_n), .ready_busy_output(rb),
      .protect_accelerate_pin(pap));
   nfc_flash_model nfc_flash_model_i (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
      .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_ce_n(fl_ce_n),
      .protect_accelerate_pin(pap), .fl_dq_i(fl_dq_i), .ready_busy_output(rb));

   ////////////////////////////////////////////////////////////////////////
   // Register port cycles and comparison
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Poll busy under a bound; a hang shows as a mismatch
   task automatic poll(output logic [31:0] s);
      rd(REG_STATUS, s);
      for (int i = 0; i < 3000 && s[0] !== 1'b0; i++)
         rd(REG_STATUS, s);
      chk({31'h0, s[0]}, 32'h0);
   endtask
   task automatic op(input logic [31:0] c, input logic [21:0] a, input logic [15:0] d,
                     output logic [31:0] s);
      wr(REG_ADDR, {10'h000, a});
      wr(REG_WDATA, {16'h0000, d});
      wr(REG_CTRL, c);
      poll(s);
   endtask
   task automatic rd_arr(input logic [21:0] a, output logic [31:0] d);
      logic [31:0] s;
      op(NFC_OP_READ, a, 16'h0000, s);
      rd(REG_RDATA, d);
      d = {16'h0000, d[15:0]};
   endtask
   function automatic logic [15:0] pat(input logic [21:0] a);
      return {a[7:0], ~a[7:0]};
   endfunction

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Cut a hang short
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         bad_count++;
         final_report;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd_arr(22'h000100, v); chk(v, pat(22'h100));
      rd(4'hF, v); chk(v, 32'h0);
      op(32'h0000000F, 22'h0, 16'h0, st); chk(st[7], 1'b1);
      op(NFC_OP_PROGRAM, 22'h000100, 16'h1234, st);
      rd_arr(22'h000100, v); chk(v, pat(22'h100) & 16'h1234);
      op(NFC_OP_PROGRAM, 22'h000100, 16'hFFFF, st);
      rd_arr(22'h000100, v); chk(v, pat(22'h100) & 16'h1234);
      // Reset written while programming runs must be refused
      wr(REG_ADDR, 32'h200);
      wr(REG_WDATA, 32'h0F0F);
      wr(REG_CTRL, NFC_OP_PROGRAM);
      wr(REG_CTRL, NFC_OP_RESET);
      rd(REG_STATUS, st); chk(st[7], 1'b1);
      poll(st);
      rd_arr(22'h000200, v); chk(v, pat(22'h200) & 16'h0F0F);
      // Identification stays until reset at an arbitrary address
      op(NFC_OP_IDENT, 22'h000000, 16'h0000, st); chk(st[4], 1'b1);
      rd_arr(22'h000005, v); chk(v, 16'h3C5A);
      rd_arr(22'h000009, v); chk(v, 16'h3C5A);
      op(NFC_OP_RESET, 22'h3FFFFF, 16'h0000, st);
      rd_arr(22'h000005, v); chk(v, pat(22'h5));
      // Secured region mapping, bypass refused inside it
      op(32'h103, 22'h0, 16'h0, st); chk(st[3], 1'b1);
      chk(st[5], 1'b0); chk(pap, 1'b0);
      rd_arr(22'h000003, v); chk(v, 16'h7103);
      op(NFC_OP_BYP_IN, 22'h0, 16'h0, st); chk(st[7], 1'b1);
      op(NFC_OP_SEC_OUT, 22'h0, 16'h0, st); chk(st[3], 1'b0);
      rd_arr(22'h000003, v); chk(v, pat(22'h3));
      // Bypass programming, back to back, then exit
      op(32'h106, 22'h0, 16'h0, st); chk(st[2], 1'b1);
      chk(st[5], 1'b1); chk(pap, 1'b1);
      op(32'h107, 22'h000300, 16'h00FF, st);
      op(32'h107, 22'h000301, 16'hF0F0, st);
      op(NFC_OP_IDENT, 22'h0, 16'h0, st); chk(st[7], 1'b1);
      op(NFC_OP_BYP_OUT, 22'h0, 16'h0, st); chk(st[2], 1'b0);
      chk(st[5], 1'b0); chk(pap, 1'b0);
      rd_arr(22'h000300, v); chk(v, pat(22'h300) & 16'h00FF);
      rd_arr(22'h000301, v); chk(v, pat(22'h301) & 16'hF0F0);
      op(NFC_OP_BYP_PROG, 22'h0, 16'h0, st); chk(st[7], 1'b1);
      final_report;
   end
endmodule

`default_nettype wire
